// >>> rtl/sim_irq_pkg.sv
// Constants and types for the interrupt and low-power control block
package sim_irq_pkg;
  localparam int NUM_SRC = 13;
  localparam int ADDR_W = 20;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_BREAK_STATUS = 16'hfe00;
  localparam logic [15:0] IDX_BREAK_FLAG_CTRL = 16'hfe03;
  localparam logic [15:0] IDX_STATUS_HIGH = 16'hfe04;
  localparam logic [15:0] IDX_STATUS_MID = 16'hfe05;
  localparam logic [15:0] IDX_STATUS_LOW = 16'hfe06;
  localparam logic [15:0] IDX_CONFIG_ONE = 16'h001f;
  // Field positions
  localparam int BIT_STOPWAIT_FLAG = 1;
  localparam int BIT_BREAK_CLEAR_EN = 7;
  localparam int BIT_SHORT_RECOVERY = 7;
  localparam int BIT_WATCHDOG_DISABLE = 0;
  // Reset values
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_CONFIG_ONE = 8'h00;
  // Vectors, upper byte address of each pair
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_SWI = 16'hfffc;
  localparam logic [15:0] VEC_TABLE [NUM_SRC] = '{
    16'hfffa, 16'hfff6, 16'hfff4, 16'hfff2, 16'hfff0, 16'hffee, 16'hffec,
    16'hffe8, 16'hffe6, 16'hffe4, 16'hffe2, 16'hffe0, 16'hffde};
  // Source indices in priority order, 0 highest
  localparam int SRC_PIN = 0;
  localparam int SRC_T1_CH0 = 1;
  localparam int SRC_T1_CH1 = 2;
  localparam int SRC_T1_OVF = 3;
  localparam int SRC_T2_CH0 = 4;
  localparam int SRC_T2_CH1 = 5;
  localparam int SRC_T2_OVF = 6;
  localparam int SRC_TWOWIRE = 7;
  localparam int SRC_SCI_ERR = 8;
  localparam int SRC_SCI_RX = 9;
  localparam int SRC_SCI_TX = 10;
  localparam int SRC_KEYPAD = 11;
  localparam int SRC_CONVERTER = 12;
  // Stop recovery in internal oscillator cycles
  localparam int RECOVERY_LONG = 4096;
  localparam int RECOVERY_SHORT = 32;
  localparam int CNT_W = 13;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [3:0] {
    PWR_RUN = 4'b0001,
    PWR_WAIT = 4'b0010,
    PWR_STOP = 4'b0100,
    PWR_RECOVER = 4'b1000
  } power_state_t;
endpackage

// >>> rtl/irq_arb_if.sv
// Request lines and arbitration result between control and arbiter
`timescale 1ns/1ps
interface irq_arb_if;
  logic [sim_irq_pkg::NUM_SRC-1:0] req;
  logic any;
  logic [3:0] index;
  logic [15:0] vector;
  modport ctrl (output req, input any, index, vector);
  modport arb (input req, output any, index, vector);
endinterface

// >>> rtl/irq_priority_arbiter.sv
// Fixed priority encoder over the maskable sources
`timescale 1ns/1ps
module irq_priority_arbiter (
  irq_arb_if.arb bus
);
  logic [3:0] win;
  always_comb
  begin
    win = 4'h0;
    // Walk from lowest to highest so the highest pending wins
    for (int k = sim_irq_pkg::NUM_SRC - 1; k >= 0; k--)
    begin
      if (bus.req[k])
      begin
        win = 4'(k);
      end
    end
  end
  assign bus.any = |bus.req;
  assign bus.index = win;
  assign bus.vector = sim_irq_pkg::VEC_TABLE[win];
endmodule // irq_priority_arbiter

// >>> rtl/stop_recovery_timer.sv
// Saturating counter timing the stop recovery on oscillator ticks
`timescale 1ns/1ps
module stop_recovery_timer #(
  parameter int LONG_COUNT = sim_irq_pkg::RECOVERY_LONG
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_hold,
  input wire logic i_tick,
  input wire logic i_short,
  output logic o_done
);
  localparam logic [sim_irq_pkg::CNT_W-1:0] LONG_N = sim_irq_pkg::CNT_W'(LONG_COUNT);
  localparam logic [sim_irq_pkg::CNT_W-1:0] SHORT_N =
    sim_irq_pkg::CNT_W'(sim_irq_pkg::RECOVERY_SHORT);
  logic [sim_irq_pkg::CNT_W-1:0] count_reg;
  logic [sim_irq_pkg::CNT_W-1:0] limit;
  assign limit = i_short ? SHORT_N : LONG_N;
  always_ff @(posedge i_clk)
  begin
    if (i_rst || i_hold)
    begin
      count_reg <= '0;
    end
    else if (i_tick && count_reg != limit)
    begin
      count_reg <= count_reg + {{(sim_irq_pkg::CNT_W - 1){1'b0}}, 1'b1};
    end
  end
  assign o_done = !i_hold && count_reg == limit;
endmodule // stop_recovery_timer

// >>> rtl/sim_interrupt_lowpower_control.sv
// Interrupt vectoring, status flags, break and low-power control
`timescale 1ns/1ps
module sim_interrupt_lowpower_control #(
  parameter int RECOVERY_LONG_COUNT = sim_irq_pkg::RECOVERY_LONG
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [sim_irq_pkg::NUM_SRC-1:0] i_src_flag,
  input wire logic [sim_irq_pkg::NUM_SRC-1:0] i_src_enable,
  input wire logic i_reset_req,
  input wire logic i_break_req,
  input wire logic i_break_exit,
  input wire logic i_ccr_mask,
  input wire logic i_insn_boundary,
  input wire logic i_swi_exec,
  input wire logic i_vector_fetched,
  input wire logic i_wait_exec,
  input wire logic i_stop_exec,
  input wire logic i_internal_osc_clock_tick,
  output logic o_vector_valid,
  output logic [15:0] o_vector,
  output logic o_stack_start,
  output logic o_clear_mask,
  output logic o_cpu_clk_en,
  output logic o_periph_clk_en,
  output logic o_osc_out_en,
  output logic o_watchdog_run,
  output logic o_break_active,
  output logic o_flag_clear_allow,
  input wire logic [sim_irq_pkg::ADDR_W-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [sim_irq_pkg::ADDR_W-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready
);
  irq_arb_if arb_bus ();
  sim_irq_pkg::power_state_t pwr_reg;
  logic [sim_irq_pkg::NUM_SRC-1:0] req;
  logic [sim_irq_pkg::NUM_SRC-1:0] status_reg;
  logic latch_valid_reg;
  logic [15:0] latch_vector_reg;
  logic break_active_reg;
  logic break_pending_reg;
  logic swi_pending_reg;
  logic break_clear_enable_reg;
  logic stopwait_flag_reg;
  logic [7:0] config_one_reg;
  logic vector_valid_reg;
  logic [15:0] vector_reg;
  logic stack_start_reg;
  logic clear_mask_reg;
  logic wake;
  logic recovery_done;
  logic stop_hold;
  // Bus slave state
  logic aw_held_reg;
  logic w_held_reg;
  logic [sim_irq_pkg::ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic do_write;
  logic [15:0] widx;
  logic [15:0] ridx;
  logic [7:0] status_high;
  logic [7:0] status_mid;
  logic [7:0] status_low;

  // Pending request needs the source's own enable
  assign req = i_src_flag & i_src_enable;
  assign arb_bus.req = req;

  irq_priority_arbiter u_arb (
    .bus(arb_bus)
  );

  assign stop_hold = pwr_reg == sim_irq_pkg::PWR_STOP;

  stop_recovery_timer #(
    .LONG_COUNT(RECOVERY_LONG_COUNT)
  ) u_timer (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_hold(stop_hold),
    .i_tick(i_internal_osc_clock_tick),
    .i_short(config_one_reg[sim_irq_pkg::BIT_SHORT_RECOVERY]),
    .o_done(recovery_done)
  );

  // Status flags mirror the pending requests
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      status_reg <= '0;
    end
    else
    begin
      status_reg <= req;
    end
  end

  assign status_high = {status_reg[sim_irq_pkg::SRC_T2_CH0], status_reg[sim_irq_pkg::SRC_T1_OVF],
    status_reg[sim_irq_pkg::SRC_T1_CH1], status_reg[sim_irq_pkg::SRC_T1_CH0], 1'b0,
    status_reg[sim_irq_pkg::SRC_PIN], 2'b00};
  assign status_mid = {status_reg[sim_irq_pkg::SRC_KEYPAD], status_reg[sim_irq_pkg::SRC_SCI_TX],
    status_reg[sim_irq_pkg::SRC_SCI_RX], status_reg[sim_irq_pkg::SRC_SCI_ERR],
    status_reg[sim_irq_pkg::SRC_TWOWIRE], 1'b0, status_reg[sim_irq_pkg::SRC_T2_OVF],
    status_reg[sim_irq_pkg::SRC_T2_CH1]};
  assign status_low = {7'h00, status_reg[sim_irq_pkg::SRC_CONVERTER]};

  // Latched maskable interrupt, frozen until its vector is fetched
  always_ff @(posedge i_clk)
  begin
    if (i_rst || i_reset_req)
    begin
      latch_valid_reg <= 1'b0;
      latch_vector_reg <= 16'h0000;
    end
    else if (latch_valid_reg)
    begin
      if (i_vector_fetched && !i_reset_req && !break_pending_reg && !swi_pending_reg)
      begin
        latch_valid_reg <= 1'b0;
      end
    end
    else if (i_insn_boundary && !i_ccr_mask && arb_bus.any)
    begin
      latch_valid_reg <= 1'b1;
      latch_vector_reg <= arb_bus.vector;
    end
  end

  // Software interrupt ignores the mask
  always_ff @(posedge i_clk)
  begin
    if (i_rst || i_reset_req)
    begin
      swi_pending_reg <= 1'b0;
    end
    else if (i_swi_exec)
    begin
      swi_pending_reg <= 1'b1;
    end
    else if (i_vector_fetched && !break_pending_reg)
    begin
      swi_pending_reg <= 1'b0;
    end
  end

  // Break forces the software interrupt vector and marks break mode
  always_ff @(posedge i_clk)
  begin
    if (i_rst || i_reset_req)
    begin
      break_pending_reg <= 1'b0;
      break_active_reg <= 1'b0;
    end
    else
    begin
      if (i_break_req && !break_active_reg)
      begin
        break_pending_reg <= 1'b1;
        break_active_reg <= 1'b1;
      end
      else if (i_vector_fetched)
      begin
        break_pending_reg <= 1'b0;
      end
      if (i_break_exit && !i_break_req)
      begin
        break_active_reg <= 1'b0;
      end
    end
  end

  // Vector selection: reset, then break or software, then latched source
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      vector_valid_reg <= 1'b0;
      vector_reg <= sim_irq_pkg::VEC_RESET;
    end
    else if (i_reset_req)
    begin
      vector_valid_reg <= 1'b1;
      vector_reg <= sim_irq_pkg::VEC_RESET;
    end
    else if (break_pending_reg || swi_pending_reg)
    begin
      vector_valid_reg <= 1'b1;
      vector_reg <= sim_irq_pkg::VEC_SWI;
    end
    else
    begin
      vector_valid_reg <= latch_valid_reg;
      vector_reg <= latch_valid_reg ? latch_vector_reg : sim_irq_pkg::VEC_RESET;
    end
  end

  assign wake = |req || i_break_req || i_reset_req;

  // Power state machine
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      pwr_reg <= sim_irq_pkg::PWR_RUN;
    end
    else
    begin
      unique case (pwr_reg)
        sim_irq_pkg::PWR_RUN:
        begin
          if (i_stop_exec)
          begin
            pwr_reg <= sim_irq_pkg::PWR_STOP;
          end
          else if (i_wait_exec)
          begin
            pwr_reg <= sim_irq_pkg::PWR_WAIT;
          end
        end
        sim_irq_pkg::PWR_WAIT:
        begin
          if (wake)
          begin
            pwr_reg <= sim_irq_pkg::PWR_RUN;
          end
        end
        sim_irq_pkg::PWR_STOP:
        begin
          if (wake)
          begin
            pwr_reg <= sim_irq_pkg::PWR_RECOVER;
          end
        end
        sim_irq_pkg::PWR_RECOVER:
        begin
          if (recovery_done)
          begin
            pwr_reg <= sim_irq_pkg::PWR_RUN;
          end
        end
        default:
        begin
          pwr_reg <= sim_irq_pkg::PWR_RUN;
        end
      endcase
    end
  end

  // Stacking strobe after wake from wait by an enabled request, or after completed recovery
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      stack_start_reg <= 1'b0;
    end
    else
    begin
      stack_start_reg <= (pwr_reg == sim_irq_pkg::PWR_WAIT && |req) ||
        (pwr_reg == sim_irq_pkg::PWR_RECOVER && recovery_done);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      clear_mask_reg <= 1'b0;
    end
    else
    begin
      clear_mask_reg <= pwr_reg == sim_irq_pkg::PWR_RUN && (i_wait_exec || i_stop_exec);
    end
  end

  // Break during wait or stop; a set in the same cycle beats the clear
  always_ff @(posedge i_clk)
  begin
    if (i_rst || i_reset_req)
    begin
      stopwait_flag_reg <= 1'b0;
    end
    else if (i_break_req && (pwr_reg == sim_irq_pkg::PWR_WAIT ||
      pwr_reg == sim_irq_pkg::PWR_STOP))
    begin
      stopwait_flag_reg <= 1'b1;
    end
    else if (do_write && widx == sim_irq_pkg::IDX_BREAK_STATUS && wstrb_reg[0] &&
      !wdata_reg[sim_irq_pkg::BIT_STOPWAIT_FLAG])
    begin
      stopwait_flag_reg <= 1'b0;
    end
  end

  // Software written control bits
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      break_clear_enable_reg <= 1'b0;
      config_one_reg <= sim_irq_pkg::RST_CONFIG_ONE;
    end
    else if (do_write && wstrb_reg[0])
    begin
      if (widx == sim_irq_pkg::IDX_BREAK_FLAG_CTRL)
      begin
        break_clear_enable_reg <= wdata_reg[sim_irq_pkg::BIT_BREAK_CLEAR_EN];
      end
      if (widx == sim_irq_pkg::IDX_CONFIG_ONE)
      begin
        config_one_reg <= wdata_reg[7:0];
      end
    end
  end

  // Clock and oscillator gating from the power state
  assign o_cpu_clk_en = pwr_reg == sim_irq_pkg::PWR_RUN;
  assign o_periph_clk_en = pwr_reg == sim_irq_pkg::PWR_RUN ||
    pwr_reg == sim_irq_pkg::PWR_WAIT;
  assign o_osc_out_en = o_periph_clk_en;
  assign o_watchdog_run = !config_one_reg[sim_irq_pkg::BIT_WATCHDOG_DISABLE] &&
    o_periph_clk_en;
  // Peripherals gate both steps of their clear sequences with this
  assign o_flag_clear_allow = !break_active_reg || break_clear_enable_reg;
  assign o_break_active = break_active_reg;
  assign o_vector_valid = vector_valid_reg;
  assign o_vector = vector_reg;
  assign o_stack_start = stack_start_reg;
  assign o_clear_mask = clear_mask_reg;

  // AXI4-Lite write path: address and data in either order
  assign o_awready = !aw_held_reg && !bvalid_reg;
  assign o_wready = !w_held_reg && !bvalid_reg;
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  assign widx = awaddr_reg[17:2];

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end
    else
    begin
      if (i_awvalid && o_awready)
      begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= i_awaddr;
      end
      else if (do_write)
      begin
        aw_held_reg <= 1'b0;
      end
      if (i_wvalid && o_wready)
      begin
        w_held_reg <= 1'b1;
        wdata_reg <= i_wdata;
        wstrb_reg <= i_wstrb;
      end
      else if (do_write)
      begin
        w_held_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= sim_irq_pkg::RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_reg <= 1'b1;
      // Interrupt status registers accept and ignore writes
      unique case (widx)
        sim_irq_pkg::IDX_BREAK_STATUS, sim_irq_pkg::IDX_BREAK_FLAG_CTRL,
        sim_irq_pkg::IDX_STATUS_HIGH, sim_irq_pkg::IDX_STATUS_MID,
        sim_irq_pkg::IDX_STATUS_LOW, sim_irq_pkg::IDX_CONFIG_ONE:
          bresp_reg <= sim_irq_pkg::RESP_OKAY;
        default:
          bresp_reg <= sim_irq_pkg::RESP_SLVERR;
      endcase
    end
    else if (i_bready)
    begin
      bvalid_reg <= 1'b0;
    end
  end

  assign o_bvalid = bvalid_reg;
  assign o_bresp = bresp_reg;

  // AXI4-Lite read path
  assign o_arready = !rvalid_reg;
  assign ridx = i_araddr[17:2];

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= sim_irq_pkg::RESP_OKAY;
    end
    else if (i_arvalid && o_arready)
    begin
      rvalid_reg <= 1'b1;
      rresp_reg <= sim_irq_pkg::RESP_OKAY;
      unique case (ridx)
        sim_irq_pkg::IDX_BREAK_STATUS:
          rdata_reg <= {30'h0000_0000, stopwait_flag_reg, 1'b0};
        sim_irq_pkg::IDX_BREAK_FLAG_CTRL:
          rdata_reg <= {24'h00_0000, break_clear_enable_reg, 7'h00};
        sim_irq_pkg::IDX_STATUS_HIGH:
          rdata_reg <= {24'h00_0000, status_high};
        sim_irq_pkg::IDX_STATUS_MID:
          rdata_reg <= {24'h00_0000, status_mid};
        sim_irq_pkg::IDX_STATUS_LOW:
          rdata_reg <= {24'h00_0000, status_low};
        sim_irq_pkg::IDX_CONFIG_ONE:
          rdata_reg <= {24'h00_0000, config_one_reg};
        default:
        begin
          rdata_reg <= 32'h0000_0000;
          rresp_reg <= sim_irq_pkg::RESP_SLVERR;
        end
      endcase
    end
    else if (i_rready)
    begin
      rvalid_reg <= 1'b0;
    end
  end

  assign o_rvalid = rvalid_reg;
  assign o_rdata = rdata_reg;
  assign o_rresp = rresp_reg;
endmodule // sim_interrupt_lowpower_control

// >>> dv/sim_irq_asserts.sv
// Concurrent checks on the interrupt and low-power control ports
`timescale 1ns/1ps
module sim_irq_asserts #(
  parameter int RECOVERY_LONG_COUNT = 4096
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [sim_irq_pkg::NUM_SRC-1:0] i_src_flag,
  input wire logic [sim_irq_pkg::NUM_SRC-1:0] i_src_enable,
  input wire logic i_reset_req,
  input wire logic i_break_req,
  input wire logic i_swi_exec,
  input wire logic i_wait_exec,
  input wire logic i_stop_exec,
  input wire logic o_vector_valid,
  input wire logic [15:0] o_vector,
  input wire logic o_stack_start,
  input wire logic o_clear_mask,
  input wire logic o_cpu_clk_en,
  input wire logic o_periph_clk_en,
  input wire logic o_osc_out_en,
  input wire logic o_watchdog_run,
  input wire logic o_break_active
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_rst);
  property p_reset_vec;
    i_reset_req |=> o_vector_valid && o_vector == sim_irq_pkg::VEC_RESET;
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("reset vector wrong");
  property p_swi;
    i_swi_exec && !i_reset_req && !o_vector_valid ##1 !i_reset_req
      |=> o_vector_valid && o_vector == sim_irq_pkg::VEC_SWI;
  endproperty
  a_swi: assert property (p_swi) else $error("swi vector wrong");
  property p_break;
    i_break_req && !o_break_active && !i_reset_req |=> o_break_active;
  endproperty
  a_break: assert property (p_break) else $error("break not entered");
  property p_mask_clr;
    (i_wait_exec || i_stop_exec) && o_cpu_clk_en && !i_reset_req |=> o_clear_mask;
  endproperty
  a_mask_clr: assert property (p_mask_clr) else $error("mask not cleared");
  property p_wait;
    i_wait_exec && !i_stop_exec && o_cpu_clk_en && !i_reset_req && !i_break_req
      |=> !o_cpu_clk_en && o_periph_clk_en;
  endproperty
  a_wait: assert property (p_wait) else $error("wait clocks wrong");
  property p_wake;
    !o_cpu_clk_en && o_periph_clk_en && (|(i_src_flag & i_src_enable)) && !i_reset_req
      && !i_break_req |=> o_cpu_clk_en ##[0:1] o_stack_start;
  endproperty
  a_wake: assert property (p_wake) else $error("wait wake wrong");
  property p_stop;
    i_stop_exec && o_cpu_clk_en && !i_reset_req && !i_break_req
      |=> !o_osc_out_en && !o_periph_clk_en;
  endproperty
  a_stop: assert property (p_stop) else $error("stop clocks wrong");
  property p_stop_stack;
    !o_osc_out_en |-> !o_stack_start;
  endproperty
  a_stop_stack: assert property (p_stop_stack) else $error("early stacking");
  property p_watchdog;
    o_watchdog_run |-> o_periph_clk_en;
  endproperty
  a_watchdog: assert property (p_watchdog) else $error("watchdog clock wrong");
endmodule // sim_irq_asserts
bind sim_interrupt_lowpower_control sim_irq_asserts
  #(.RECOVERY_LONG_COUNT(RECOVERY_LONG_COUNT)) chk (.*);

// >>> dv/cpu_core_model.sv
// CPU core and oscillator stand-in facing the control block
`timescale 1ns/1ps
module cpu_core_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_vector_valid,
  input wire logic i_slow,
  output logic o_fetched,
  output logic o_boundary,
  output logic o_tick
);
  logic [2:0] wait_reg;
  logic seen_reg;
  logic [1:0] div_reg;
  // Fetch each offered vector once, promptly or late
  always_ff @(posedge i_clk)
  begin
    o_fetched <= 1'b0;
    if (i_rst || !i_vector_valid)
    begin
      wait_reg <= 3'd0;
      seen_reg <= 1'b0;
    end
    else if (!seen_reg && wait_reg == (i_slow ? 3'd6 : 3'd0))
    begin
      o_fetched <= 1'b1;
      seen_reg <= 1'b1;
    end
    else if (!seen_reg)
      wait_reg <= wait_reg + 3'd1;
  end
  // Instruction end every second cycle, oscillator tick every third
  always_ff @(posedge i_clk)
  begin
    div_reg <= (i_rst || div_reg == 2'd2) ? 2'd0 : div_reg + 2'd1;
    o_tick <= !i_rst && div_reg == 2'd2;
    o_boundary <= !i_rst && !o_boundary;
  end
endmodule // cpu_core_model

// >>> dv/tb_sim_interrupt_lowpower_control.sv
// Self-checking bench for the interrupt and low-power control block
`timescale 1ns/1ps
module tb_sim_interrupt_lowpower_control;
  localparam int LONG_CNT = 8;
  logic clk = 1'b0, rst = 1'b1, rreq = 1'b0, brk = 1'b0, brk_exit = 1'b0, mask = 1'b1;
  logic software_interrupt_instruction = 1'b0, wexec = 1'b0, sexec = 1'b0, slow = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [12:0] flag = '0, en = '0, f, e;
  logic [19:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, d;
  logic fetched, boundary, tick, vvalid, stack, clrm, cpu_en, per_en, osc_en, wd_run;
  logic brk_act, allow, awready, wready, bvalid, arready, rvalid;
  logic [15:0] vector;
  logic [1:0] bresp, rresp, r;
  int err_count = 0, samples_checked = 0, n;
  integer seed = 32'hc170_9b66;
  always #2.5 clk = ~clk;
  sim_interrupt_lowpower_control #(.RECOVERY_LONG_COUNT(LONG_CNT)) DUT (
    .i_clk(clk), .i_rst(rst), .i_src_flag(flag), .i_src_enable(en), .i_reset_req(rreq),
    .i_break_req(brk), .i_break_exit(brk_exit), .i_ccr_mask(mask), .i_insn_boundary(boundary),
    .i_swi_exec(software_interrupt_instruction), .i_vector_fetched(fetched), .i_wait_exec(wexec), .i_stop_exec(sexec),
    .i_internal_osc_clock_tick(tick), .o_vector_valid(vvalid), .o_vector(vector), .o_stack_start(stack),
    .o_clear_mask(clrm), .o_cpu_clk_en(cpu_en), .o_periph_clk_en(per_en),
    .o_osc_out_en(osc_en), .o_watchdog_run(wd_run), .o_break_active(brk_act),
    .o_flag_clear_allow(allow), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(1'b1), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(1'b1));
  cpu_core_model partner (.i_clk(clk), .i_rst(rst), .i_vector_valid(vvalid), .i_slow(slow),
    .o_fetched(fetched), .o_boundary(boundary), .o_tick(tick));
  function automatic logic [15:0] exp_vec(input logic [12:0] q);
    exp_vec = 16'h0000;
    for (int i = 12; i >= 0; i--)
      if (q[i])
        exp_vec = sim_irq_pkg::VEC_TABLE[i];
  endfunction
  function automatic logic [23:0] exp_stat(input logic [12:0] q);
    exp_stat = {q[4:1], 1'b0, q[0], 2'b00, q[11:7], 1'b0, q[6:5], 7'h00, q[12]};
  endfunction
  task chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x)
    begin
      err_count++;
      $display("MISMATCH t=%0t got %h expected %h", $time, g, x);
    end
  endtask
  task wr(input logic [15:0] idx, input logic [7:0] v);
    awaddr <= 20'({idx, 2'b00});
    wdata <= {24'h00_0000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (bvalid !== 1'b1);
    r = bresp;
  endtask
  task rd(input logic [15:0] idx);
    araddr <= 20'({idx, 2'b00});
    arvalid <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end
    while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask
  task expect_vec(input logic [15:0] x);
    n = 0;
    while (vvalid !== 1'b1 && n < 60)
    begin
      @(posedge clk);
      n++;
    end
    chk(32'(vector), 32'(x));
  endtask
  task settle();
    repeat (10) @(posedge clk);
    while (vvalid === 1'b1) @(posedge clk);
  endtask
  task wait_stack(input int lim);
    n = 0;
    while (stack !== 1'b1 && n < lim)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  task stop_run(input logic s, input int lo);
    wr(sim_irq_pkg::IDX_CONFIG_ONE, {s, 7'h00});
    sexec <= 1'b1;
    @(posedge clk);
    sexec <= 1'b0;
    repeat (4) @(posedge clk);
    chk(32'({osc_en, per_en, cpu_en}), 0);
    flag <= 13'h0001;
    wait_stack(500);
    chk(32'(n >= lo && n <= lo + 11), 1);
    flag <= '0;
    settle();
  endtask
  task close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #50000;
    err_count++;
    close_out();
  end
  initial
  begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 7; i++)
    begin
      rd(i == 6 ? sim_irq_pkg::IDX_CONFIG_ONE : sim_irq_pkg::IDX_BREAK_STATUS + 16'(i));
      chk(d, 0);
    end
    rd(16'h0100);
    chk(32'(r), 32'(sim_irq_pkg::RESP_SLVERR));
    $display("reset test done");
    en <= '1;
    repeat (6)
    begin
      f = 13'($random(seed));
      flag <= f;
      repeat (3) @(posedge clk);
      wr(sim_irq_pkg::IDX_STATUS_MID, 8'hff);
      chk(32'(r), 32'(sim_irq_pkg::RESP_OKAY));
      for (int i = 0; i < 3; i++)
      begin
        rd(sim_irq_pkg::IDX_STATUS_HIGH + 16'(i));
        chk(d, 32'(exp_stat(f) >> (16 - 8 * i)) & 32'h0000_00ff);
      end
    end
    $display("status test done");
    mask <= 1'b0;
    for (int k = 0; k < 8; k++)
    begin
      f = (k == 0) ? '1 : (k == 1) ? 13'h1000 : 13'($random(seed));
      e = 13'($random(seed));
      if (k == 2) {f, e} = {13'h0070, 13'h0040};
      if (k == 3) {f, e} = {13'h0006, 13'h0002};
      if ((f & e) == 13'h0000) e = '1;
      flag <= f;
      en <= e;
      expect_vec(exp_vec(f & e));
      flag <= '0;
      settle();
    end
    en <= '1;
    slow <= 1'b1;
    flag <= 13'h1000;
    expect_vec(16'hffde);
    flag <= 13'h1001;
    repeat (3) @(posedge clk);
    chk(32'(vector), 32'h0000_ffde);
    flag <= '0;
    slow <= 1'b0;
    settle();
    mask <= 1'b1;
    flag <= '1;
    repeat (10) @(posedge clk);
    chk(32'(vvalid), 0);
    software_interrupt_instruction <= 1'b1;
    @(posedge clk);
    software_interrupt_instruction <= 1'b0;
    expect_vec(sim_irq_pkg::VEC_SWI);
    flag <= '0;
    settle();
    $display("priority test done");
    brk <= 1'b1;
    @(posedge clk);
    brk <= 1'b0;
    expect_vec(sim_irq_pkg::VEC_SWI);
    chk(32'({brk_act, allow}), 32'h0000_0002);
    wr(sim_irq_pkg::IDX_BREAK_FLAG_CTRL, 8'h80);
    rd(sim_irq_pkg::IDX_BREAK_FLAG_CTRL);
    chk(d, 32'h0000_0080);
    chk(32'(allow), 1);
    wr(sim_irq_pkg::IDX_BREAK_FLAG_CTRL, 8'h00);
    brk_exit <= 1'b1;
    @(posedge clk);
    brk_exit <= 1'b0;
    settle();
    chk(32'({brk_act, allow}), 1);
    for (int k = 0; k < 2; k++)
    begin
      wexec <= 1'b1;
      @(posedge clk);
      wexec <= 1'b0;
      @(posedge clk);
      chk(32'({clrm, cpu_en, per_en}), 32'h0000_0005);
      if (k == 0)
      begin
        flag <= 13'h0001;
        wait_stack(20);
        chk(32'(n <= 3 && cpu_en), 1);
        flag <= '0;
      end
      else
      begin
        brk <= 1'b1;
        @(posedge clk);
        brk <= 1'b0;
        expect_vec(sim_irq_pkg::VEC_SWI);
        rd(sim_irq_pkg::IDX_BREAK_STATUS);
        chk(32'(d[1]), 1);
        wr(sim_irq_pkg::IDX_BREAK_STATUS, 8'h00);
        rd(sim_irq_pkg::IDX_BREAK_STATUS);
        chk(32'(d[1]), 0);
        brk_exit <= 1'b1;
        @(posedge clk);
        brk_exit <= 1'b0;
      end
      settle();
    end
    $display("wait and break test done");
    stop_run(1'b0, 3 * LONG_CNT - 3);
    stop_run(1'b1, 3 * 32 - 3);
    sexec <= 1'b1;
    @(posedge clk);
    sexec <= 1'b0;
    brk <= 1'b1;
    @(posedge clk);
    brk <= 1'b0;
    expect_vec(sim_irq_pkg::VEC_SWI);
    rd(sim_irq_pkg::IDX_BREAK_STATUS);
    chk(32'(d[1]), 1);
    wait_stack(500);
    chk(32'(cpu_en), 1);
    brk_exit <= 1'b1;
    @(posedge clk);
    brk_exit <= 1'b0;
    settle();
    wr(sim_irq_pkg::IDX_CONFIG_ONE, 8'h01);
    @(posedge clk);
    chk(32'(wd_run), 0);
    wr(sim_irq_pkg::IDX_CONFIG_ONE, 8'h00);
    @(posedge clk);
    chk(32'(wd_run), 1);
    rreq <= 1'b1;
    @(posedge clk);
    rreq <= 1'b0;
    expect_vec(sim_irq_pkg::VEC_RESET);
    $display("stop and reset test done");
    close_out();
  end
endmodule // tb_sim_interrupt_lowpower_control
